// ---- kps_defines.svh ----
// Constants for the pointer decrement and key search command block
//
// What this block does
// - Decrement command lowers pointer by exactly one
// - First byte of chip moves to previous last_usable_address
// - Status raised on decrement at array's very first byte
// - Pointer left unchanged on that underflow
// - Search command takes exactly key-length key bytes
// - Key bytes stored in buffer at memory end
// - Search starts once last key byte arrives
// - Equal key: pointer to record, status low
// - No equal key: next higher record, status high
// - Duplicates: earliest record in cascade chosen
// - Bare repeat search advances then compares again
// - Other commands except restore end repeat mode
// - Key length lies from one to 255
`ifndef KPS_DEFINES_SVH
`define KPS_DEFINES_SVH

// Opcodes
`define KPS_OP_DEC      8'h02
`define KPS_OP_SRCH     8'h03
`define KPS_OP_RSTR     8'h0b

// Address layout
`define KPS_LOC_W       16
`define KPS_CHIP_W      4
`define KPS_BUF_END     16'hffff
`define KPS_MAX_KEY     255

// Reset values
`define KPS_PTR_RST     16'h0000
`define KPS_CHIP_RST    4'h0

`endif

// ---- kps_pkg.sv ----
// Types for the pointer decrement and key search command block
`include "kps_defines.svh"
package kps_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_KEY,
        ST_ADV,
        ST_RD,
        ST_CMP
    } state_e;

    typedef struct packed {
        state_e                            st;
        logic [`KPS_CHIP_W-1:0]            pchip;
        logic [`KPS_LOC_W-1:0]             ploc;
        logic                              status;
        logic                              rpt;
        logic                              done;
        logic [7:0]                        kcnt;
        logic [`KPS_CHIP_W-1:0]            rchip;
        logic [`KPS_LOC_W-1:0]             roff;
        logic [7:0]                        bidx;
        logic                              bwe;
        logic [`KPS_LOC_W-1:0]             baddr;
        logic [7:0]                        bdata;
        logic                              oth_v;
        logic [7:0]                        oth_b;
        logic [`KPS_MAX_KEY-1:0][7:0]      key;
    } state_s;

endpackage

// ---- kps_ptr_dec.sv ----
// Pointer decrement step with chip crossing and underflow detect
`timescale 1ns/1ps
module kps_ptr_dec #(
    parameter int CHIP_W = 4,
    parameter int LOC_W  = 16
) (
    // Current pointer
    input  wire logic [CHIP_W-1:0] chip,
    input  wire logic [LOC_W-1:0]  loc,
    // Last usable byte of each chip
    input  wire logic [LOC_W-1:0]  last_addr,
    // Next pointer
    output logic      [CHIP_W-1:0] chip_next,
    output logic      [LOC_W-1:0]  loc_next,
    output logic                   underflow
);

    // One step back; from byte 0, into the preceding chip at its last usable byte
    always_comb begin
        underflow = 1'b0;
        chip_next = chip;
        loc_next  = loc - 1'b1;
        if (loc == '0) begin
            if (chip == '0) begin
                underflow = 1'b1;
                loc_next  = loc;
            end else begin
                chip_next = chip - 1'b1;
                loc_next  = last_addr;
            end
        end
    end

endmodule

// ---- kps_core.sv ----
// Command execution for pointer decrement and key search
`timescale 1ns/1ps
`include "kps_defines.svh"
module kps_core #(
    parameter int NCHIP = 16
) (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RSTN,
    // Host byte port
    input  wire logic                   CMD_VALID,
    input  wire logic                   CMD_IS_CMD,
    input  wire logic [7:0]             CMD_BYTE,
    output logic                        CMD_READY,
    // Commands for other logic
    output logic                        OTHER_VALID,
    output logic [7:0]                  OTHER_BYTE,
    // Record format from setup
    input  wire logic [7:0]             KEY_LEN,
    input  wire logic [7:0]             PTR_LEN,
    input  wire logic [`KPS_LOC_W-1:0]  LAST_ADDR,
    // Key buffer write, broadcast to all chips
    output logic                        BUF_WE,
    output logic [`KPS_LOC_W-1:0]       BUF_ADDR,
    output logic [7:0]                  BUF_WDATA,
    // Record memory read
    output logic [`KPS_CHIP_W-1:0]      RD_CHIP,
    output logic [`KPS_LOC_W-1:0]       RD_ADDR,
    input  wire logic [7:0]             RD_DATA,
    // Results
    output logic [`KPS_CHIP_W-1:0]      PTR_CHIP,
    output logic [`KPS_LOC_W-1:0]       PTR_LOC,
    output logic                        STATUS,
    output logic                        DONE,
    output logic                        REPEAT_MODE
);

    ////////////////////////////////////////////////////////////////////////
    // State and helpers

    kps_pkg::state_s                r_reg;
    kps_pkg::state_s                r_next;
    logic [`KPS_CHIP_W-1:0]         dec_chip;
    logic [`KPS_LOC_W-1:0]          dec_loc;
    logic                           dec_uf;
    logic [`KPS_LOC_W-1:0]          rec_len;
    logic [`KPS_LOC_W-1:0]          off_next;
    logic                           is_cmd;
    logic                           is_data;
    logic [7:0]                     key_byte;

    // Record ends at or below the last usable byte
    function automatic logic fits(input logic [`KPS_LOC_W-1:0] off,
                                  input logic [`KPS_LOC_W-1:0] len,
                                  input logic [`KPS_LOC_W-1:0] last);
        logic [`KPS_LOC_W:0] end_b;
        end_b = {1'b0, off} + {1'b0, len} - 1'b1;
        return end_b <= {1'b0, last};
    endfunction

    kps_ptr_dec #(
        .CHIP_W    (`KPS_CHIP_W),
        .LOC_W     (`KPS_LOC_W)
    ) u_dec (
        .chip      (r_reg.pchip),
        .loc       (r_reg.ploc),
        .last_addr (LAST_ADDR),
        .chip_next (dec_chip),
        .loc_next  (dec_loc),
        .underflow (dec_uf)
    );

    // Decoded inputs and record stride
    assign is_cmd   = CMD_VALID && CMD_IS_CMD && r_reg.st == kps_pkg::ST_IDLE;
    assign is_data  = CMD_VALID && !CMD_IS_CMD && r_reg.st == kps_pkg::ST_KEY;
    assign rec_len  = {8'h00, KEY_LEN} + {8'h00, PTR_LEN};
    assign off_next = r_reg.roff + rec_len;
    assign key_byte = r_reg.key[r_reg.bidx];

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer

    always_comb begin
        r_next       = r_reg;
        r_next.done  = 1'b0;
        r_next.bwe   = 1'b0;
        r_next.oth_v = 1'b0;
        case (r_reg.st)
            kps_pkg::ST_IDLE: begin
                if (is_cmd) begin
                    if (CMD_BYTE == `KPS_OP_DEC) begin
                        r_next.rpt    = 1'b0;
                        r_next.status = dec_uf;
                        r_next.pchip  = dec_chip;
                        r_next.ploc   = dec_loc;
                        r_next.done   = 1'b1;
                    end else if (CMD_BYTE == `KPS_OP_SRCH) begin
                        if (r_reg.rpt) begin
                            r_next.rchip = r_reg.pchip;
                            r_next.roff  = r_reg.ploc;
                            r_next.st    = kps_pkg::ST_ADV;
                        end else begin
                            r_next.kcnt = 8'h00;
                            r_next.st   = kps_pkg::ST_KEY;
                        end
                    end else begin
                        if (CMD_BYTE != `KPS_OP_RSTR) begin
                            r_next.rpt = 1'b0;
                        end
                        r_next.oth_v = 1'b1;
                        r_next.oth_b = CMD_BYTE;
                    end
                end
            end
            kps_pkg::ST_KEY: begin
                if (is_data) begin
                    r_next.key[r_reg.kcnt] = CMD_BYTE;
                    r_next.bwe   = 1'b1;
                    r_next.bdata = CMD_BYTE;
                    r_next.baddr = `KPS_BUF_END - {8'h00, KEY_LEN} + 1'b1
                                   + {8'h00, r_reg.kcnt};
                    r_next.kcnt  = r_reg.kcnt + 1'b1;
                    if (r_reg.kcnt == KEY_LEN - 1'b1) begin
                        r_next.rchip = '0;
                        r_next.roff  = '0;
                        r_next.bidx  = 8'h00;
                        r_next.st    = kps_pkg::ST_RD;
                    end
                end
            end
            kps_pkg::ST_ADV: begin
                r_next.bidx = 8'h00;
                r_next.st   = kps_pkg::ST_RD;
                if (fits(off_next, rec_len, LAST_ADDR)) begin
                    r_next.roff = off_next;
                end else if (r_reg.rchip != `KPS_CHIP_W'(NCHIP - 1)) begin
                    r_next.rchip = r_reg.rchip + 1'b1;
                    r_next.roff  = '0;
                end else begin
                    r_next.status = 1'b1;
                    r_next.done   = 1'b1;
                    r_next.rpt    = 1'b1;
                    r_next.st     = kps_pkg::ST_IDLE;
                end
            end
            kps_pkg::ST_RD: begin
                if (fits(r_reg.roff, rec_len, LAST_ADDR)) begin
                    r_next.st = kps_pkg::ST_CMP;
                end else begin
                    r_next.status = 1'b1;
                    r_next.done   = 1'b1;
                    r_next.rpt    = 1'b1;
                    r_next.st     = kps_pkg::ST_IDLE;
                end
            end
            kps_pkg::ST_CMP: begin
                if (RD_DATA < key_byte) begin
                    r_next.st = kps_pkg::ST_ADV;
                end else if (RD_DATA > key_byte) begin
                    r_next.pchip  = r_reg.rchip;
                    r_next.ploc   = r_reg.roff;
                    r_next.status = 1'b1;
                    r_next.done   = 1'b1;
                    r_next.rpt    = 1'b1;
                    r_next.st     = kps_pkg::ST_IDLE;
                end else if (r_reg.bidx == KEY_LEN - 1'b1) begin
                    r_next.pchip  = r_reg.rchip;
                    r_next.ploc   = r_reg.roff;
                    r_next.status = 1'b0;
                    r_next.done   = 1'b1;
                    r_next.rpt    = 1'b1;
                    r_next.st     = kps_pkg::ST_IDLE;
                end else begin
                    r_next.bidx = r_reg.bidx + 1'b1;
                    r_next.st   = kps_pkg::ST_RD;
                end
            end
            default: r_next.st = kps_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            r_reg       <= '0;
            r_reg.st    <= kps_pkg::ST_IDLE;
            r_reg.pchip <= `KPS_CHIP_RST;
            r_reg.ploc  <= `KPS_PTR_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign CMD_READY   = r_reg.st == kps_pkg::ST_IDLE
                         || r_reg.st == kps_pkg::ST_KEY;
    assign OTHER_VALID = r_reg.oth_v;
    assign OTHER_BYTE  = r_reg.oth_b;
    assign BUF_WE      = r_reg.bwe;
    assign BUF_ADDR    = r_reg.baddr;
    assign BUF_WDATA   = r_reg.bdata;
    assign RD_CHIP     = r_reg.rchip;
    assign RD_ADDR     = r_reg.roff + {8'h00, r_reg.bidx};
    assign PTR_CHIP    = r_reg.pchip;
    assign PTR_LOC     = r_reg.ploc;
    assign STATUS      = r_reg.status;
    assign DONE        = r_reg.done;
    assign REPEAT_MODE = r_reg.rpt;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_DEC_STEP: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_cmd && CMD_BYTE == `KPS_OP_DEC && r_reg.ploc != '0
        |=> DONE && !STATUS && PTR_LOC == $past(r_reg.ploc) - 1'b1
            && $stable(PTR_CHIP))
        else $error("decrement did not step by one");

    AST_DEC_CROSS: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_cmd && CMD_BYTE == `KPS_OP_DEC && r_reg.ploc == '0
        && r_reg.pchip != '0
        |=> PTR_LOC == $past(LAST_ADDR)
            && PTR_CHIP == $past(r_reg.pchip) - 1'b1)
        else $error("decrement did not cross into previous chip");

    AST_DEC_UF_STAT: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_cmd && CMD_BYTE == `KPS_OP_DEC && r_reg.ploc == '0
        && r_reg.pchip == '0 |=> STATUS && DONE)
        else $error("underflow status missing");

    AST_DEC_UF_HOLD: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_cmd && CMD_BYTE == `KPS_OP_DEC && r_reg.ploc == '0
        && r_reg.pchip == '0 |=> $stable(PTR_LOC) && $stable(PTR_CHIP))
        else $error("pointer moved on underflow");

    AST_KEY_STORE: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_data |=> BUF_WE && BUF_WDATA == $past(CMD_BYTE)
            && BUF_ADDR == `KPS_BUF_END - {8'h00, $past(KEY_LEN)}
               + 1'b1 + {8'h00, $past(r_reg.kcnt)})
        else $error("key byte not written to buffer end");

    AST_KEY_LAST: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_data && r_reg.kcnt == KEY_LEN - 1'b1
        |=> r_reg.st == kps_pkg::ST_RD && RD_CHIP == '0
            && RD_ADDR == '0)
        else $error("search did not start after last key byte");

    AST_KEY_WAIT: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_data && r_reg.kcnt != KEY_LEN - 1'b1
        |=> r_reg.st == kps_pkg::ST_KEY)
        else $error("search started before all key bytes");

    AST_MATCH: assert property (
        @(posedge CLK) disable iff (!RSTN)
        r_reg.st == kps_pkg::ST_CMP && RD_DATA == key_byte
        && r_reg.bidx == KEY_LEN - 1'b1
        |=> DONE && !STATUS && REPEAT_MODE
            && PTR_LOC == $past(r_reg.roff))
        else $error("match not reported");

    AST_MISS: assert property (
        @(posedge CLK) disable iff (!RSTN)
        r_reg.st == kps_pkg::ST_CMP && RD_DATA > key_byte
        |=> DONE && STATUS && PTR_CHIP == $past(r_reg.rchip))
        else $error("next higher record not reported");

    AST_RPT_GO: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_cmd && CMD_BYTE == `KPS_OP_SRCH && REPEAT_MODE
        |=> r_reg.st == kps_pkg::ST_ADV
        ##1 ({RD_CHIP, RD_ADDR} != $past({PTR_CHIP, PTR_LOC}, 2) || DONE))
        else $error("repeat search did not advance");

    AST_RPT_END: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_cmd && CMD_BYTE != `KPS_OP_SRCH && CMD_BYTE != `KPS_OP_RSTR
        |=> !REPEAT_MODE)
        else $error("repeat mode not ended");

    AST_RPT_KEEP: assert property (
        @(posedge CLK) disable iff (!RSTN)
        is_cmd && CMD_BYTE == `KPS_OP_RSTR |=> $stable(REPEAT_MODE))
        else $error("restore changed repeat mode");

endmodule

// ---- kps_mem_model.sv ----
// Record memory model for two chips, answering reads one cycle late
`timescale 1ns/1ps
`include "kps_defines.svh"
module kps_mem_model (
    // Clock
    input  wire logic                  clk,
    // Key buffer write
    input  wire logic                  buf_we,
    input  wire logic [`KPS_LOC_W-1:0] buf_addr,
    input  wire logic [7:0]            buf_wdata,
    // Record read
    input  wire logic [`KPS_CHIP_W-1:0] rd_chip,
    input  wire logic [`KPS_LOC_W-1:0] rd_addr,
    output logic      [7:0]            rd_data
);
    logic [7:0]  mem [0:31];
    logic [7:0]  kbuf [0:255];
    logic [15:0] keys [0:5] = '{16'h0010, 16'h0020, 16'h0020,
                                16'h0020, 16'h0040, 16'h0050};

    ////////////////////////////////////////////////////////////////////////
    // Records of key 2 and pointer 1 bytes, sorted by key
    initial begin
        rd_data = 8'h5a;
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'hee;
        end
        for (int r = 0; r < 6; r++) begin
            mem[(r / 3) * 16 + (r % 3) * 3] = keys[r][15:8];
            mem[(r / 3) * 16 + (r % 3) * 3 + 1] = keys[r][7:0];
            mem[(r / 3) * 16 + (r % 3) * 3 + 2] = 8'(r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer capture; reads outside the array give a toggling pattern
    always @(posedge clk) begin
        if (buf_we === 1'b1) begin
            kbuf[buf_addr[7:0]] <= buf_wdata;
        end
        if (rd_chip < 2 && rd_addr < 16) begin
            rd_data <= mem[{rd_chip[0], rd_addr[3:0]}];
        end else begin
            rd_data <= ~rd_data;
        end
    end
endmodule

// ---- tb.sv ----
// Self-checking bench for the decrement and key search block
`timescale 1ns/1ps
`include "kps_defines.svh"
module tb;
    logic        clk, rstn, cmd_valid, cmd_is_cmd, cmd_ready, other_valid;
    logic        buf_we, status, done, repeat_mode;
    logic [7:0]  cmd_byte, other_byte, buf_wdata, rd_data;
    logic [15:0] buf_addr, rd_addr, ptr_loc;
    logic [3:0]  rd_chip, ptr_chip;
    int          fail_count, comparisons, bwe_cnt, done_cnt;

    typedef struct packed {
        logic [1:0]  op;
        logic [15:0] key;
        logic [3:0]  chip;
        logic [15:0] loc;
        logic        stat;
        logic        rpt;
    } row_s;

    // Op 0 keyed search, 1 bare search, 2 decrement
    row_s rows [0:11] = '{
        '{2'd0, 16'h0020, 4'h0, 16'h0003, 1'b0, 1'b1},
        '{2'd1, 16'h0000, 4'h0, 16'h0006, 1'b0, 1'b1},
        '{2'd1, 16'h0000, 4'h1, 16'h0000, 1'b0, 1'b1},
        '{2'd2, 16'h0000, 4'h0, 16'h0008, 1'b0, 1'b0},
        '{2'd0, 16'h0040, 4'h1, 16'h0003, 1'b0, 1'b1},
        '{2'd1, 16'h0000, 4'h1, 16'h0006, 1'b1, 1'b1},
        '{2'd2, 16'h0000, 4'h1, 16'h0005, 1'b0, 1'b0},
        '{2'd0, 16'h0030, 4'h1, 16'h0003, 1'b1, 1'b1},
        '{2'd2, 16'h0000, 4'h1, 16'h0002, 1'b0, 1'b0},
        '{2'd0, 16'h0005, 4'h0, 16'h0000, 1'b1, 1'b1},
        '{2'd2, 16'h0000, 4'h0, 16'h0000, 1'b1, 1'b0},
        '{2'd0, 16'h0060, 4'h0, 16'h0000, 1'b1, 1'b1}
    };

    kps_core #(.NCHIP(2)) dut_u (
        .CLK(clk), .RSTN(rstn), .CMD_VALID(cmd_valid),
        .CMD_IS_CMD(cmd_is_cmd), .CMD_BYTE(cmd_byte),
        .CMD_READY(cmd_ready), .OTHER_VALID(other_valid),
        .OTHER_BYTE(other_byte), .KEY_LEN(8'h02), .PTR_LEN(8'h01),
        .LAST_ADDR(16'h0008), .BUF_WE(buf_we), .BUF_ADDR(buf_addr),
        .BUF_WDATA(buf_wdata), .RD_CHIP(rd_chip), .RD_ADDR(rd_addr),
        .RD_DATA(rd_data), .PTR_CHIP(ptr_chip), .PTR_LOC(ptr_loc),
        .STATUS(status), .DONE(done), .REPEAT_MODE(repeat_mode)
    );

    kps_mem_model mem_u (
        .clk(clk), .buf_we(buf_we), .buf_addr(buf_addr),
        .buf_wdata(buf_wdata), .rd_chip(rd_chip), .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and pulse counters
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (buf_we === 1'b1) bwe_cnt++;
        if (done === 1'b1) done_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////
    // Report and end of run
    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Present one byte at the falling edge, hold until taken
    task automatic send(input logic c, input logic [7:0] b);
        int n = 0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_is_cmd = c;
        cmd_byte = b;
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n == 200) begin
            fail_count++;
            finish_test();
        end
        @(posedge clk);
    endtask

    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(negedge clk);
            cmd_valid = 1'b0;
            n++;
        end while (done !== 1'b1 && n < 300);
        if (done !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask

    task automatic run(input row_s r);
        int n;
        send(1'b1, r.op == 2'd2 ? `KPS_OP_DEC : `KPS_OP_SRCH);
        if (r.op == 2'd0) begin
            send(1'b0, r.key[15:8]);
            send(1'b0, r.key[7:0]);
            @(negedge clk);
            cmd_valid = 1'b0;
            check(cmd_ready, 1'b0, "busy while searching");
        end
        wait_done(n);
        if (r.op == 2'd2) check(n, 1, "dec latency");
        if (r.op == 2'd0) check({mem_u.kbuf[8'hfe], mem_u.kbuf[8'hff]},
                                r.key, "key buffer");
        check({ptr_chip, ptr_loc, status, repeat_mode},
              {r.chip, r.loc, r.stat, r.rpt}, "result");
    endtask

    // Pass-on of a foreign opcode and its effect on repeat mode
    task automatic pass_on(input logic [7:0] b, input logic rpt);
        send(1'b1, b);
        @(negedge clk);
        cmd_valid = 1'b0;
        check({other_valid, other_byte}, {1'b1, b}, "pass on");
        @(negedge clk);
        check(repeat_mode, rpt, "repeat flag");
    endtask

    task automatic check_reset();
        check({cmd_ready, done, status, repeat_mode, other_valid, buf_we,
               ptr_chip, ptr_loc}, 26'h2000000, "reset");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int b0;
        int d0;
        int n0;
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_is_cmd = 1'b0;
        cmd_byte = 8'h00;
        repeat (5) @(negedge clk);
        check_reset();
        rstn = 1'b1;
        foreach (rows[i]) run(rows[i]);
        pass_on(`KPS_OP_RSTR, 1'b1);
        pass_on(8'h06, 1'b0);
        b0 = bwe_cnt;
        d0 = done_cnt;
        send(1'b0, 8'h77);
        repeat (3) @(negedge clk);
        cmd_valid = 1'b0;
        check(bwe_cnt + done_cnt, b0 + d0, "idle literal");
        send(1'b1, `KPS_OP_SRCH);
        send(1'b0, 8'h00);
        send(1'b1, `KPS_OP_DEC);
        send(1'b0, 8'h10);
        wait_done(n0);
        check({ptr_chip, ptr_loc, status}, 21'h0, "dropped cmd");
        repeat (3) @(negedge clk);
        check(done_cnt - d0, 1, "one done");
        check(bwe_cnt - b0, 2, "two writes");
        send(1'b1, `KPS_OP_SRCH);
        @(negedge clk);
        rstn = 1'b0;
        cmd_valid = 1'b0;
        repeat (2) @(negedge clk);
        check_reset();
        rstn = 1'b1;
        run(rows[0]);
        finish_test();
    end
endmodule
